// >>> bench/smc_monitor.sv
// checker on the link between the core end and the device end
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sleep_instr,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_rdata,
   input wire logic sys_reset,
   input wire logic adc_enabled,
   input wire logic core_halt,
   input wire logic [7:0] clk_run,
   input wire logic adc_start,
   input wire logic wake_reset,
   input wire logic sleeping,
   input wire logic hold_state
);
   logic [2:0] mode; // selected sleep mode code
   assign mode = ctrl_rdata[`SMC_SM_MSB:`SMC_SM_LSB];
   // ==========================================
   // one clock domain
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_enter; $rose(sleeping) |-> $past(sleep_instr) && $past(ctrl_rdata[`SMC_BIT_SE]); endproperty
   a_enter: assert property (p_enter) else $error("sleep without enable and instruction");
   property p_reserved; sleep_instr && !sleeping && mode inside {3'h4, 3'h5} |=> !sleeping; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code entered sleep");
   property p_idle; sleeping && $past(sleeping) && mode == `SMC_M_IDLE
      |-> clk_run[`SMC_CK_FLASH:`SMC_CK_CPU] == 2'h0 && clk_run[`SMC_CK_IO] && clk_run[`SMC_CK_ADC]; endproperty
   a_idle: assert property (p_idle) else $error("idle clock set wrong");
   property p_noise; sleeping && $past(sleeping) && mode == `SMC_M_ADCNR
      |-> clk_run[`SMC_CK_IO:`SMC_CK_CPU] == 3'h0 && clk_run[`SMC_CK_ADC]; endproperty
   a_noise: assert property (p_noise) else $error("noise mode clock set wrong");
   property p_pdown; sleeping && $past(sleeping) && mode == `SMC_M_PDOWN
      |-> clk_run[`SMC_CK_ASY:`SMC_CK_CPU] == 5'h00 && !clk_run[`SMC_CK_OSC] && !clk_run[`SMC_CK_PLL]; endproperty
   a_pdown: assert property (p_pdown) else $error("power-down clocks running");
   property p_stby; sleeping && $past(sleeping) && mode == `SMC_M_STBY
      |-> clk_run[`SMC_CK_OSC] && !clk_run[`SMC_CK_PLL]; endproperty
   a_stby: assert property (p_stby) else $error("standby oscillator or pll wrong");
   property p_adc; sleep_instr && ctrl_rdata[`SMC_BIT_SE] && adc_enabled && mode inside {`SMC_M_IDLE, `SMC_M_ADCNR}
      |=> adc_start; endproperty
   a_adc: assert property (p_adc) else $error("no conversion start on entry");
   property p_stall; $fell(core_halt) && !$past(sys_reset) |-> $past(core_halt, 6); endproperty
   a_stall: assert property (p_stall) else $error("halt too short on wake");
   property p_rst; sys_reset && sleeping |-> ##[1:6] wake_reset; endproperty
   a_rst: assert property (p_rst) else $error("reset did not wake to vector");
   property p_hold; sleeping |-> hold_state; endproperty
   a_hold: assert property (p_hold) else $error("state not frozen in sleep");
   property p_keep; $changed(ctrl_rdata) |-> $past(ctrl_wr) || $past(ctrl_wr, 2); endproperty
   a_keep: assert property (p_keep) else $error("control changed without write");
endmodule : smc_monitor

// >>> bench/smc_tb_top.sv
// self-checking bench for both controller ends
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic irq_pending = 0, sys_reset = 0, adc_enabled = 1, timer_irq_ok = 0, xtal_selected = 1, err;
   logic timer_async = 1; // async timer on its own clock
   logic timer_running = 1; // async timer enabled
   logic [12:0] wake_src = 13'h0000;
   int n_mismatch = 0, check_count = 0, li, la, lp, ls, lt, lx, ls2;
   logic seen_irq, seen_rst, seen_adc;
   always #2 pclk = ~pclk; // 250 MHz
   smc_link_if smc_link_if_i ();
   smc_core smc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_pending(irq_pending), .wake_src(wake_src), .sys_reset(sys_reset), .adc_enabled(adc_enabled),
      .timer_async(timer_async), .timer_running(timer_running), .timer_irq_ok(timer_irq_ok),
      .xtal_selected(xtal_selected),
      .link(smc_link_if_i.core));
   smc_device smc_device_i (.pclk(pclk), .presetn(presetn), .link(smc_link_if_i.dev));
   smc_monitor smc_monitor_i (.pclk(pclk), .presetn(presetn), .sleep_instr(smc_link_if_i.sleep_instr),
      .ctrl_wr(smc_link_if_i.ctrl_wr), .ctrl_rdata(smc_link_if_i.ctrl_rdata), .sys_reset(smc_link_if_i.sys_reset),
      .adc_enabled(smc_link_if_i.adc_enabled), .core_halt(smc_link_if_i.core_halt),
      .clk_run(smc_link_if_i.clk_run), .adc_start(smc_link_if_i.adc_start),
      .wake_reset(smc_link_if_i.wake_reset), .sleeping(smc_link_if_i.sleeping),
      .hold_state(smc_link_if_i.hold_state));
   // ==========================================
   // compare, report, bus cycle
   task report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) begin n_mismatch++; report_and_stop(); end
      // idle edge, so a following call never re-raises psel in this step
      @(posedge pclk);
   endtask : apb
   // halt ends, then three more edges; flags the wake pulses
   task wait_run(output int lat);
      lat = 0; seen_irq = 0; seen_rst = 0;
      while (smc_link_if_i.core_halt !== 1'b0 && lat < 300) begin
         @(posedge pclk);
         lat++;
         // pulses stand in the cycle in which halt drops
         seen_irq |= smc_link_if_i.wake_irq;
         seen_rst |= smc_link_if_i.wake_reset;
      end
      repeat (3) begin
         @(posedge pclk);
         seen_irq |= smc_link_if_i.wake_irq;
         seen_rst |= smc_link_if_i.wake_reset;
      end
      if (lat >= 300) begin n_mismatch++; report_and_stop(); end
   endtask : wait_run
   function automatic logic [7:0] exp_clk(input logic [2:0] m);
      logic [7:0] e;
      e = 8'h00;
      e[`SMC_CK_IO] = (m == `SMC_M_IDLE);
      e[`SMC_CK_ADC] = (m <= `SMC_M_ADCNR);
      e[`SMC_CK_PLL] = (m <= `SMC_M_ADCNR);
      e[`SMC_CK_ASY] = m inside {`SMC_M_IDLE, `SMC_M_ADCNR} || (m == `SMC_M_PSAVE && timer_running)
         || (m == `SMC_M_XSTBY && timer_running && timer_async);
      e[`SMC_CK_TOSC] = timer_async && (m inside {`SMC_M_IDLE, `SMC_M_ADCNR} || e[`SMC_CK_ASY]);
      // a synchronously clocked timer keeps the main source alive in power-save
      e[`SMC_CK_OSC] = m inside {`SMC_M_IDLE, `SMC_M_ADCNR, `SMC_M_STBY, `SMC_M_XSTBY}
         || (m == `SMC_M_PSAVE && timer_running && !timer_async);
      return e;
   endfunction : exp_clk
   // ==========================================
   // sleep in mode m, offer source s, wake; lat is the final wake
   task go(input logic [2:0] m, input int s, input logic ok, output int lat);
      apb(1'b1, `SMC_ADDR_CTRL, {28'h0, m, 1'b1});
      apb(1'b1, `SMC_ADDR_WAKE, 32'h0);
      seen_adc = 0;
      repeat (3) begin
         @(posedge pclk);
         seen_adc |= smc_link_if_i.adc_start;
      end
      chk(seen_adc, m <= `SMC_M_ADCNR && adc_enabled);
      chk(smc_link_if_i.sleeping, 1);
      chk(smc_link_if_i.clk_run, exp_clk(m));
      chk(smc_link_if_i.hold_state, 1);
      wake_src[s] <= 1'b1; irq_pending <= 1'b1;
      if (!ok) begin
         repeat (40) @(posedge pclk);
         chk(smc_link_if_i.sleeping, 1);
         wake_src[`SMC_W_WDT] <= 1'b1;
      end
      wait_run(lat);
      wake_src <= 13'h0000; irq_pending <= 1'b0;
      chk(seen_irq, 1);
      chk(smc_link_if_i.ctrl_rdata, {4'h0, m, 1'b1});
      // software drops the enable again right after waking
      apb(1'b1, `SMC_ADDR_CTRL, {28'h0, m, 1'b0});
      $display("mode %0d done, wake latency %0d", m, lat);
   endtask : go
   task t_refuse();
      apb(1'b0, `SMC_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      // last pass asks for standby without a crystal selected
      xtal_selected <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `SMC_ADDR_CTRL, (c == 0) ? 32'h0 : {28'h0, 3'(c + 3), 1'b1});
         apb(1'b1, `SMC_ADDR_WAKE, 32'h0);
         repeat (4) @(posedge pclk);
         chk(smc_link_if_i.sleeping, 0);
         apb(1'b0, `SMC_ADDR_CTRL, 32'h0);
         chk(rd, (c == 0) ? 32'h0 : {28'h0, 3'(c + 3), 1'b1});
      end
      xtal_selected <= 1'b1;
      $display("refusal test done");
   endtask : t_refuse
   task t_reset();
      int l;
      apb(1'b1, `SMC_ADDR_CTRL, {28'h0, `SMC_M_PDOWN, 1'b1});
      apb(1'b1, `SMC_ADDR_WAKE, 32'h0);
      repeat (3) @(posedge pclk);
      sys_reset <= 1'b1;
      wait_run(l);
      sys_reset <= 1'b0;
      chk({seen_rst, seen_irq}, 2'b10);
      apb(1'b0, `SMC_ADDR_STATUS, 32'h0);
      chk(rd[3], 1);
      $display("reset wake test done");
   endtask : t_reset
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_refuse();
      apb(1'b1, `SMC_ADDR_FUSE, 32'h2);
      timer_irq_ok <= 1'b1;
      go(`SMC_M_IDLE, `SMC_W_OTHER_IO, 1, li);
      go(`SMC_M_ADCNR, `SMC_W_OTHER_IO, 0, la);
      go(`SMC_M_PDOWN, `SMC_W_TIMER, 0, lp);
      go(`SMC_M_PSAVE, `SMC_W_TIMER, 1, ls);
      go(`SMC_M_STBY, `SMC_W_USB_SYNC, 0, lt);
      go(`SMC_M_XSTBY, `SMC_W_TWI_ADDR, 1, lx);
      chk(lp - lt, 2 * `SMC_STARTUP_UNIT + 1 - `SMC_STBY_WAKE_CYC);
      chk(lt - li, `SMC_STBY_WAKE_CYC - 1);
      chk(lx, lt);
      chk(ls, lp);
      // synchronous timer clock, timer interrupt enables off: timer may not wake
      timer_async <= 1'b0;
      timer_irq_ok <= 1'b0;
      go(`SMC_M_PSAVE, `SMC_W_TIMER, 0, ls2);
      chk(ls2, lp);
      timer_async <= 1'b1;
      timer_irq_ok <= 1'b1;
      // converter disabled: no conversion start on idle entry
      adc_enabled <= 1'b0;
      go(`SMC_M_IDLE, `SMC_W_OTHER_IO, 1, ls2);
      chk(ls2, li);
      adc_enabled <= 1'b1;
      t_reset();
      report_and_stop();
   end
endmodule : smc_tb_top

// >>> design/smc_consts.svh
// constants shared by the sleep mode controller ends
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// ==========================================
// register map and fields
`define SMC_ADDR_CTRL 12'h000
`define SMC_ADDR_STATUS 12'h004
`define SMC_ADDR_WAKE 12'h008
`define SMC_ADDR_FUSE 12'h00C
`define SMC_BIT_SE 0
`define SMC_SM_LSB 1
`define SMC_SM_MSB 3
`define SMC_CTRL_RESET 8'h00
// ==========================================
// mode codes
`define SMC_M_IDLE 3'h0
`define SMC_M_ADCNR 3'h1
`define SMC_M_PDOWN 3'h2
`define SMC_M_PSAVE 3'h3
`define SMC_M_STBY 3'h6
`define SMC_M_XSTBY 3'h7
// ==========================================
// timing
`define SMC_STALL_CYC 4
`define SMC_STBY_WAKE_CYC 6
`define SMC_STARTUP_UNIT 16
// ==========================================
// clock gate vector bits
`define SMC_CK_CPU 0
`define SMC_CK_FLASH 1
`define SMC_CK_IO 2
`define SMC_CK_ADC 3
`define SMC_CK_ASY 4
`define SMC_CK_OSC 5
`define SMC_CK_TOSC 6
`define SMC_CK_PLL 7
// ==========================================
// wake source vector bits
`define SMC_W_EXT_LO 0
`define SMC_W_EXT_HI_LVL 1
`define SMC_W_PCINT 2
`define SMC_W_TWI_ADDR 3
`define SMC_W_TIMER 4
`define SMC_W_SPM_EE 5
`define SMC_W_ADC 6
`define SMC_W_WDT 7
`define SMC_W_OTHER_IO 8
`define SMC_W_USB_SYNC 9
`define SMC_W_USB_ASYNC 10
`define SMC_W_TWI_OTHER 11
`define SMC_W_EXT_HI_EDGE 12
`define SMC_NWAKE 13
`endif

// >>> design/smc_core.sv
// processor-side end: apb registers drive sleep instruction and enable
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_core
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_pending,
   input wire logic [12:0] wake_src,
   input wire logic sys_reset,
   input wire logic adc_enabled,
   input wire logic timer_async,
   input wire logic timer_running,
   input wire logic timer_irq_ok,
   input wire logic xtal_selected,
   smc_link_if.core link
);
   logic acc; // apb access phase
   logic [3:0] fuse_q; // fuse setting register
   logic sleep_q; // sleep instruction pulse
   logic [1:0] wake_cnt_q; // wake events seen: irq, reset
   // ==========================================
   // apb slave, zero wait states
   assign acc = psel && penable;
   assign pready = 1'b1;
   assign pslverr = acc && !(paddr == `SMC_ADDR_CTRL || paddr == `SMC_ADDR_STATUS
      || paddr == `SMC_ADDR_WAKE || paddr == `SMC_ADDR_FUSE);
   // write to the wake address issues the instruction, unless the core is halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_q <= 1'b0;
         fuse_q <= '0;
      end else begin
         sleep_q <= acc && pwrite && paddr == `SMC_ADDR_WAKE && !link.core_halt;
         if (acc && pwrite && paddr == `SMC_ADDR_FUSE) begin
            fuse_q <= pwdata[3:0];
         end
      end
   end
   // sticky wake history, each event sets its bit until reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_q <= '0;
      end else begin
         wake_cnt_q <= wake_cnt_q | {link.wake_reset, link.wake_irq};
      end
   end
   // read data from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `SMC_ADDR_CTRL: prdata <= {24'h000000, link.ctrl_rdata};
            `SMC_ADDR_STATUS: prdata <= {28'h0000000, wake_cnt_q, link.core_halt, link.sleeping};
            `SMC_ADDR_FUSE: prdata <= {28'h0000000, fuse_q};
            default: prdata <= '0;
         endcase
      end
   end
   // ==========================================
   // link drive
   assign link.ctrl_wr = acc && pwrite && paddr == `SMC_ADDR_CTRL;
   assign link.ctrl_wdata = pwdata[7:0];
   assign link.sleep_instr = sleep_q;
   assign link.irq_pending = irq_pending;
   assign link.wake_src = wake_src; // level sources held by their owners
   assign link.sys_reset = sys_reset;
   assign link.adc_enabled = adc_enabled;
   assign link.timer_async = timer_async;
   assign link.timer_running = timer_running;
   assign link.timer_irq_ok = timer_irq_ok;
   assign link.xtal_selected = xtal_selected;
   assign link.clock_source_fuses = fuse_q;
endmodule : smc_core

// >>> design/smc_device.sv
// sleep mode controller, device end
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_device
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   smc_link_if.dev link
);
   // ==========================================
   // declarations
   smc_state_t state_q; // controller state
   logic [7:0] ctrl_q; // sleep mode control register
   logic [2:0] mode_q; // mode latched at sleep entry
   logic [15:0] cnt_q; // start-up and stall counter
   logic [`SMC_NWAKE-1:0] wake_s; // synchronised wake sources
   logic [`SMC_NWAKE-1:0] allow; // sources allowed in mode
   logic wake_hit; // allowed source with enabled interrupt
   logic adc_start_q;
   logic wake_irq_q;
   logic wake_reset_q;
   logic [15:0] startup_cyc; // delay for latched mode

   // wake sources come from asynchronous logic
   smc_sync3 #(.W(`SMC_NWAKE)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(link.wake_src),
      .dout(wake_s)
   );

   // ==========================================
   // mode decode helpers
   function automatic logic [`SMC_NWAKE-1:0] wake_mask(input logic [2:0] m, input logic tok);
      logic [`SMC_NWAKE-1:0] w;
      w = '0;
      case (m)
         `SMC_M_IDLE: w = '1; // everything may wake
         `SMC_M_ADCNR: begin
            w[`SMC_W_ADC] = 1'b1;
            w[`SMC_W_WDT] = 1'b1;
            w[`SMC_W_TWI_ADDR] = 1'b1;
            w[`SMC_W_TWI_OTHER] = 1'b1;
            w[`SMC_W_TIMER] = 1'b1;
            w[`SMC_W_SPM_EE] = 1'b1;
            w[`SMC_W_EXT_HI_LVL] = 1'b1;
            w[`SMC_W_PCINT] = 1'b1;
         end
         `SMC_M_PDOWN, `SMC_M_STBY, `SMC_M_PSAVE, `SMC_M_XSTBY: begin
            w[`SMC_W_WDT] = 1'b1;
            w[`SMC_W_TWI_ADDR] = 1'b1;
            w[`SMC_W_EXT_HI_LVL] = 1'b1;
            w[`SMC_W_EXT_LO] = 1'b1;
            w[`SMC_W_PCINT] = 1'b1;
            w[`SMC_W_USB_ASYNC] = 1'b1;
            // timer wakes power-save family only with its enables set
            w[`SMC_W_TIMER] = (m == `SMC_M_PSAVE || m == `SMC_M_XSTBY) && tok;
         end
         default: w = '0;
      endcase
      return w;
   endfunction : wake_mask

   function automatic logic valid_mode(input logic [2:0] m, input logic xtal);
      logic v;
      v = 1'b0;
      case (m)
         `SMC_M_IDLE, `SMC_M_ADCNR, `SMC_M_PDOWN, `SMC_M_PSAVE: v = 1'b1;
         `SMC_M_STBY, `SMC_M_XSTBY: v = xtal;
         default: v = 1'b0; // reserved codes do not sleep
      endcase
      return v;
   endfunction : valid_mode

   // clock domain enables for a mode while asleep
   function automatic logic [7:0] clk_mask(input logic [2:0] m, input logic tasy, input logic trun);
      logic [7:0] c;
      c = '0;
      case (m)
         `SMC_M_IDLE: begin
            c = '1;
            c[`SMC_CK_CPU] = 1'b0;
            c[`SMC_CK_FLASH] = 1'b0;
            c[`SMC_CK_TOSC] = tasy;
         end
         `SMC_M_ADCNR: begin
            c = '1;
            c[`SMC_CK_CPU] = 1'b0;
            c[`SMC_CK_FLASH] = 1'b0;
            c[`SMC_CK_IO] = 1'b0;
            c[`SMC_CK_TOSC] = tasy;
         end
         `SMC_M_PDOWN: c = '0;
         `SMC_M_PSAVE: begin
            c[`SMC_CK_ASY] = trun;
            c[`SMC_CK_TOSC] = trun && tasy;
            c[`SMC_CK_OSC] = trun && !tasy;
         end
         `SMC_M_STBY: c[`SMC_CK_OSC] = 1'b1;
         `SMC_M_XSTBY: begin
            c[`SMC_CK_OSC] = 1'b1;
            c[`SMC_CK_ASY] = trun && tasy;
            c[`SMC_CK_TOSC] = trun && tasy;
         end
         default: c = '1;
      endcase
      return c;
   endfunction : clk_mask

   assign allow = wake_mask(mode_q, link.timer_irq_ok);
   assign wake_hit = link.irq_pending && |(wake_s & allow);
   // start-up delay from fuses in power-down and power-save, standby modes fixed at six, others at one
   assign startup_cyc = (mode_q == `SMC_M_STBY || mode_q == `SMC_M_XSTBY) ? 16'(`SMC_STBY_WAKE_CYC)
      : (mode_q == `SMC_M_PDOWN || mode_q == `SMC_M_PSAVE)
      ? 16'(link.clock_source_fuses * `SMC_STARTUP_UNIT + 1) : 16'd1;

   // ==========================================
   // control register, never cleared by hardware
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SMC_CTRL_RESET;
      end else if (link.ctrl_wr) begin
         ctrl_q <= link.ctrl_wdata;
      end
   end

   // ==========================================
   // sleep sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SMC_RUN;
         mode_q <= `SMC_M_IDLE;
         cnt_q <= '0;
      end else if (link.sys_reset) begin
         state_q <= SMC_RUN;
         cnt_q <= '0;
      end else begin
         case (state_q)
            SMC_RUN: begin
               if (link.sleep_instr && ctrl_q[`SMC_BIT_SE]
                  && valid_mode(ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB], link.xtal_selected)) begin
                  state_q <= SMC_SLEEP;
                  mode_q <= ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB];
               end
            end
            SMC_SLEEP: begin
               if (wake_hit) begin
                  state_q <= SMC_START;
                  cnt_q <= startup_cyc;
               end
            end
            SMC_START: begin // oscillator restart time
               if (cnt_q <= 16'd1) begin
                  state_q <= SMC_STALL;
                  cnt_q <= 16'(`SMC_STALL_CYC);
               end else begin
                  cnt_q <= cnt_q - 16'd1;
               end
            end
            SMC_STALL: begin // extra halted cycles
               if (cnt_q <= 16'd1) begin
                  state_q <= SMC_RESUME;
               end else begin
                  cnt_q <= cnt_q - 16'd1;
               end
            end
            SMC_RESUME: state_q <= SMC_RUN;
            default: state_q <= SMC_RUN;
         endcase
      end
   end

   // ==========================================
   // event pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_start_q <= 1'b0;
         wake_irq_q <= 1'b0;
         wake_reset_q <= 1'b0;
      end else begin
         adc_start_q <= state_q == SMC_RUN && link.sleep_instr && ctrl_q[`SMC_BIT_SE] && link.adc_enabled
            && (ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB] == `SMC_M_IDLE
            || ctrl_q[`SMC_SM_MSB:`SMC_SM_LSB] == `SMC_M_ADCNR);
         wake_irq_q <= state_q == SMC_RESUME && !link.sys_reset;
         wake_reset_q <= state_q != SMC_RUN && link.sys_reset;
      end
   end

   // ==========================================
   // outputs
   assign link.ctrl_rdata = ctrl_q;
   assign link.adc_start = adc_start_q;
   assign link.wake_irq = wake_irq_q;
   assign link.wake_reset = wake_reset_q;
   assign link.sleeping = state_q == SMC_SLEEP;
   assign link.core_halt = state_q != SMC_RUN;
   assign link.hold_state = state_q != SMC_RUN;
   assign link.clk_run = (state_q == SMC_RUN) ? 8'hFF
      : (state_q == SMC_SLEEP) ? clk_mask(mode_q, link.timer_async, link.timer_running)
      : 8'hFF;
endmodule : smc_device

// >>> design/smc_link_if.sv
// link between processor core side and sleep controller
`timescale 1ns/1ps
interface smc_link_if;
   logic sleep_instr; // core executes sleep, one-cycle pulse
   logic ctrl_wr; // control register write strobe
   logic [7:0] ctrl_wdata; // control write data
   logic [7:0] ctrl_rdata; // control readback
   logic irq_pending; // enabled interrupt from interrupt system
   logic [12:0] wake_src; // raw wake sources
   logic sys_reset; // any system reset request
   logic adc_enabled; // adc enable from converter
   logic timer_async; // async timer uses external clock
   logic timer_running; // async timer enabled
   logic timer_irq_ok; // timer mask and global enable both set
   logic xtal_selected; // external crystal clock option
   logic [3:0] clock_source_fuses; // start-up delay setting
   logic core_halt; // core must not fetch
   logic [7:0] clk_run; // clock domain enables
   logic adc_start; // start conversion pulse
   logic wake_irq; // run handler then continue, pulse
   logic wake_reset; // restart at reset vector, pulse
   logic sleeping; // controller asleep
   logic hold_state; // register file and sram frozen
   modport dev (input sleep_instr, ctrl_wr, ctrl_wdata, irq_pending, wake_src, sys_reset, adc_enabled,
      timer_async, timer_running, timer_irq_ok, xtal_selected, clock_source_fuses,
      output ctrl_rdata, core_halt, clk_run, adc_start, wake_irq, wake_reset, sleeping, hold_state);
   modport core (output sleep_instr, ctrl_wr, ctrl_wdata, irq_pending, wake_src, sys_reset, adc_enabled,
      timer_async, timer_running, timer_irq_ok, xtal_selected, clock_source_fuses,
      input ctrl_rdata, core_halt, clk_run, adc_start, wake_irq, wake_reset, sleeping, hold_state);
endinterface : smc_link_if

// >>> design/smc_pkg.sv
// types shared by the sleep mode controller ends
package smc_pkg;
   // controller states, one-hot
   typedef enum logic [4:0] {
      SMC_RUN = 5'h01,
      SMC_SLEEP = 5'h02,
      SMC_START = 5'h04,
      SMC_STALL = 5'h08,
      SMC_RESUME = 5'h10
   } smc_state_t;
endpackage : smc_pkg

// >>> design/smc_sync3.sv
// three-stage synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module smc_sync3 #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q; // first stage, read only by s2
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   // ==========================================
   // shift chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // ==========================================
   // agreement filter per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               dout[i] <= s3_q[i];
            end
         end
      end
   end
endmodule : smc_sync3
